// >>> rtl/timer8_regs.svh
`ifndef TIMER8_REGS_SVH
`define TIMER8_REGS_SVH

// ****************************************************************
// Register offsets (byte addresses, one aligned word each)
// ****************************************************************
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_COUNT 8'h08
`define OFS_MATCH_A 8'h0C
`define OFS_MATCH_B 8'h10
`define OFS_FLAGS 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define CA_COM_A 7:6
`define CA_COM_B 5:4
`define CA_WGM_LOW 1:0
`define CB_WGM_HIGH 3
`define FL_MATCH_B 2
`define FL_MATCH_A 1
`define FL_OVERFLOW 0

// ****************************************************************
// Counter limits, modes and encodings
// ****************************************************************
`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
`define MODE_CTC 3'h2
`define MODE_FAST_OCRA 3'h7
`define WGM_LOW_FAST 2'h3
`define WGM_LOW_PHASE 2'h1
`define COM_OFF 2'h0
`define COM_TOGGLE 2'h1
`define COM_CLEAR 2'h2
`define COM_SET 2'h3
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD 3'h2
`define RESET_BYTE 8'h00

`endif

// >>> rtl/timer8_pkg.sv
package timer8_pkg;

   // ****************************************************************
   // State records
   // ****************************************************************
   typedef struct packed {
      logic wave;
   } chan_state_t;

   typedef struct packed {
      logic [1:0] com_a;
      logic [1:0] com_b;
      logic [1:0] wgm_low;
      logic wgm_high;
      logic [7:0] count;
      logic [7:0] match_a_buf;
      logic [7:0] match_a;
      logic [7:0] match_b_buf;
      logic [7:0] match_b;
      logic dir_down;
      logic overflow_flag;
      logic match_flag_a;
      logic match_flag_b;
      logic block;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic [31:0] hrdata;
      logic hready;
      logic hresp;
      logic pin_a;
      logic oe_a_n;
      logic pin_b;
      logic oe_b_n;
   } timer_state_t;

endpackage : timer8_pkg

// >>> rtl/wave_channel.sv
`timescale 1ns/100ps
`include "timer8_regs.svh"

module wave_channel
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic tick,
   input wire logic [1:0] com,
   input wire logic fast,
   input wire logic phase,
   input wire logic toggle_ok,
   input wire logic match,
   input wire logic count_up,
   input wire logic at_top,
   input wire logic match_is_top,
   output logic wave
);
   import timer8_pkg::*;

   chan_state_t state_ff;
   chan_state_t nxt_state;
   logic pwm;
   logic inv;

   assign pwm = fast | phase;
   assign inv = com[0];
   assign wave = state_ff.wave;

   always_comb
   begin
      nxt_state = state_ff;
      if (com == `COM_TOGGLE)
      begin
         if (match && (!pwm || toggle_ok))
         begin
            nxt_state.wave = ~state_ff.wave;
         end
      end
      else if (com != `COM_OFF)
      begin
         if (!pwm)
         begin
            if (match)
            begin
               nxt_state.wave = inv;
            end
         end
         else if (fast)
         begin
            // A match equal to top is dropped; the top action alone decides
            if (tick && at_top)
            begin
               nxt_state.wave = ~inv;
            end
            else if (match && !match_is_top)
            begin
               nxt_state.wave = inv;
            end
         end
         else if (match_is_top)
         begin
            if (tick && at_top)
            begin
               nxt_state.wave = ~inv;
            end
         end
         else if (match)
         begin
            nxt_state.wave = count_up ? inv : ~inv;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

endmodule : wave_channel

// >>> rtl/timer8_waveform_mode_control.sv
`timescale 1ns/100ps
`include "timer8_regs.svh"

// Overview of operation
// - Counter runs on the system clock; the tick only enables counting, flags, wave changes and buffer loads.
// - Nonzero channel A field, except PWM value 1 with mode high bit 0, puts wave A on its pin; direction enables driver.
// - Nonzero channel B field puts wave B on its pin; direction enables driver.
// - Non-PWM channel A: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM A: 2 clears on match, sets at top; 3 the reverse.
// - PWM A value 1: off when mode high bit 0, toggle on match when 1.
// - Phase PWM A: 2 clears on up match, sets on down match; 3 reverse.
// - PWM A with match value at top and upper bit set acts at top only.
// - PWM B with match value at top and upper bit set acts at top only.
// - Non-PWM channel B: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM B: 1 reserved; 2 clear match, set top; 3 the reverse.
// - Phase PWM B: 1 reserved; 2 clear up match, set down; 3 reverse.
// - Unused bits 3 and 2 of control A always read zero.
// - Mode field: 0 normal, 1/5 phase PWM, 2 clear-on-match, 3/7 fast PWM.
// - Top is 0xFF in modes 0, 1, 3; match value A in 2, 5, 7.
// - Match writes apply at once in modes 0, 2; at top in PWM modes.
// - Overflow at max in 0, 2, 3; at bottom in 1, 5; at top in 7.
// - Fast PWM counts up to top then returns to zero next tick.
// - Phase PWM leaves a nonzero top on the next tick and counts down to bottom; a top of zero holds.

module timer8_waveform_mode_control
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic timer_tick_enable,
   input wire logic port_out_a,
   input wire logic port_dir_a,
   input wire logic port_out_b,
   input wire logic port_dir_b,
   output logic wave_pin_a,
   output logic wave_pin_a_oe_n,
   output logic wave_pin_b,
   output logic wave_pin_b_oe_n
);
   import timer8_pkg::*;

   // ****************************************************************
   // State and derived terms
   // ****************************************************************
   localparam timer_state_t STATE_RESET = '{hready: 1'b1, oe_a_n: 1'b1, oe_b_n: 1'b1,
                                            default: '0};

   timer_state_t state_ff;
   timer_state_t nxt_state;
   logic [2:0] mode;
   logic pwm;
   logic fast;
   logic phase;
   logic top_is_match_a;
   logic [7:0] top;
   logic at_top;
   logic match_a;
   logic match_b;
   logic overflow_evt;
   logic accept;
   logic wave_out_a;
   logic wave_out_b;
   logic wave_drives_a;

   // Read mux; reserved and unmapped bits read as zero
   function automatic logic [31:0] read_word(input timer_state_t s, input logic [7:0] ofs);
      logic [31:0] w;
      w = '0;
      unique case (ofs)
         `OFS_CTRL_A:
         begin
            w[`CA_COM_A] = s.com_a;
            w[`CA_COM_B] = s.com_b;
            w[`CA_WGM_LOW] = s.wgm_low;
         end
         `OFS_CTRL_B:
         begin
            w[`CB_WGM_HIGH] = s.wgm_high;
         end
         `OFS_COUNT:
         begin
            w[7:0] = s.count;
         end
         `OFS_MATCH_A:
         begin
            w[7:0] = s.match_a_buf;
         end
         `OFS_MATCH_B:
         begin
            w[7:0] = s.match_b_buf;
         end
         `OFS_FLAGS:
         begin
            w[`FL_MATCH_B] = s.match_flag_b;
            w[`FL_MATCH_A] = s.match_flag_a;
            w[`FL_OVERFLOW] = s.overflow_flag;
         end
         default:
         begin
            w = '0;
         end
      endcase
      return w;
   endfunction : read_word

   // Reserved modes 4 and 6 fall back to plain counting to 0xFF
   assign mode = {state_ff.wgm_high, state_ff.wgm_low};
   assign fast = (state_ff.wgm_low == `WGM_LOW_FAST);
   assign phase = (state_ff.wgm_low == `WGM_LOW_PHASE);
   assign pwm = fast | phase;
   assign top_is_match_a = (mode == `MODE_CTC) || (state_ff.wgm_high && state_ff.wgm_low[0]);
   assign top = top_is_match_a ? state_ff.match_a : `CNT_MAX;
   assign at_top = (state_ff.count == top);

   // A software write to the counter masks the compare on the next tick
   assign match_a = timer_tick_enable && !state_ff.block
                    && (state_ff.count == state_ff.match_a);
   assign match_b = timer_tick_enable && !state_ff.block
                    && (state_ff.count == state_ff.match_b);

   always_comb
   begin
      if (phase)
      begin
         overflow_evt = state_ff.dir_down && (state_ff.count == `CNT_BOTTOM);
      end
      else if (mode == `MODE_FAST_OCRA)
      begin
         overflow_evt = at_top;
      end
      else
      begin
         overflow_evt = (state_ff.count == `CNT_MAX);
      end
   end

   assign accept = hsel && hready && htrans[`HTRANS_NONSEQ_BIT];

   // Toggle code in PWM without the mode high bit hands the pin back to the port
   assign wave_drives_a = (state_ff.com_a != `COM_OFF)
                          && !(pwm && !state_ff.wgm_high && (state_ff.com_a == `COM_TOGGLE));

   // ****************************************************************
   // Waveform channels
   // ****************************************************************
   wave_channel u_chan_a
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .tick(timer_tick_enable),
      .com(state_ff.com_a),
      .fast(fast),
      .phase(phase),
      .toggle_ok(state_ff.wgm_high),
      .match(match_a),
      .count_up(!state_ff.dir_down),
      .at_top(at_top),
      .match_is_top(state_ff.com_a[1] && (state_ff.match_a == top)),
      .wave(wave_out_a)
   );

   // Channel B never toggles in PWM: value 1 is reserved there
   wave_channel u_chan_b
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .tick(timer_tick_enable),
      .com(state_ff.com_b),
      .fast(fast),
      .phase(phase),
      .toggle_ok(1'b0),
      .match(match_b),
      .count_up(!state_ff.dir_down),
      .at_top(at_top),
      .match_is_top(state_ff.com_b[1] && (state_ff.match_b == top)),
      .wave(wave_out_b)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      nxt_state = state_ff;

      // Counting sequence
      if (timer_tick_enable)
      begin
         nxt_state.block = 1'b0;
         if (phase)
         begin
            if (!state_ff.dir_down)
            begin
               if (at_top && (top != `CNT_BOTTOM))
               begin
                  nxt_state.dir_down = 1'b1;
                  nxt_state.count = state_ff.count - 8'h01;
               end
               else if (!at_top)
               begin
                  nxt_state.count = state_ff.count + 8'h01;
               end
            end
            else if (state_ff.count == `CNT_BOTTOM)
            begin
               nxt_state.dir_down = 1'b0;
               nxt_state.count = state_ff.count + 8'h01;
            end
            else
            begin
               nxt_state.count = state_ff.count - 8'h01;
            end
         end
         else
         begin
            nxt_state.dir_down = 1'b0;
            nxt_state.count = at_top ? `CNT_BOTTOM : state_ff.count + 8'h01;
         end

         // Double buffer of the match values loads at top
         if (pwm && at_top)
         begin
            nxt_state.match_a = state_ff.match_a_buf;
            nxt_state.match_b = state_ff.match_b_buf;
         end
      end

      // Hardware events set the flags; a same-cycle clear loses
      if (state_ff.wr_pend && (state_ff.wr_addr == `OFS_FLAGS))
      begin
         if (hwdata[`FL_OVERFLOW])
         begin
            nxt_state.overflow_flag = 1'b0;
         end
         if (hwdata[`FL_MATCH_A])
         begin
            nxt_state.match_flag_a = 1'b0;
         end
         if (hwdata[`FL_MATCH_B])
         begin
            nxt_state.match_flag_b = 1'b0;
         end
      end
      if (timer_tick_enable && overflow_evt)
      begin
         nxt_state.overflow_flag = 1'b1;
      end
      if (match_a)
      begin
         nxt_state.match_flag_a = 1'b1;
      end
      if (match_b)
      begin
         nxt_state.match_flag_b = 1'b1;
      end

      // Data phase of a write
      if (state_ff.wr_pend)
      begin
         unique case (state_ff.wr_addr)
            `OFS_CTRL_A:
            begin
               nxt_state.com_a = hwdata[`CA_COM_A];
               nxt_state.com_b = hwdata[`CA_COM_B];
               nxt_state.wgm_low = hwdata[`CA_WGM_LOW];
            end
            `OFS_CTRL_B:
            begin
               nxt_state.wgm_high = hwdata[`CB_WGM_HIGH];
            end
            `OFS_COUNT:
            begin
               nxt_state.count = hwdata[7:0];
               nxt_state.block = 1'b1;
            end
            `OFS_MATCH_A:
            begin
               nxt_state.match_a_buf = hwdata[7:0];
            end
            `OFS_MATCH_B:
            begin
               nxt_state.match_b_buf = hwdata[7:0];
            end
            default:
            begin
               nxt_state.wr_pend = 1'b0;
            end
         endcase
      end

      // Outside PWM the buffer is transparent
      if (!pwm)
      begin
         nxt_state.match_a = nxt_state.match_a_buf;
         nxt_state.match_b = nxt_state.match_b_buf;
      end

      // Address phase; only whole-word writes act, reads of any size act
      nxt_state.wr_pend = accept && hwrite && (hsize == `HSIZE_WORD);
      nxt_state.wr_addr = haddr[7:0];
      if (accept && !hwrite)
      begin
         nxt_state.hrdata = read_word(state_ff, haddr[7:0]);
      end
      nxt_state.hready = 1'b1;
      nxt_state.hresp = 1'b0;

      // Pin muxing, registered so the pins never glitch between modes
      nxt_state.pin_a = wave_drives_a ? wave_out_a : port_out_a;
      nxt_state.oe_a_n = !port_dir_a;
      nxt_state.pin_b = (state_ff.com_b != `COM_OFF) ? wave_out_b : port_out_b;
      nxt_state.oe_b_n = !port_dir_b;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         state_ff <= STATE_RESET;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign hrdata = state_ff.hrdata;
   assign hreadyout = state_ff.hready;
   assign hresp = state_ff.hresp;
   assign wave_pin_a = state_ff.pin_a;
   assign wave_pin_a_oe_n = state_ff.oe_a_n;
   assign wave_pin_b = state_ff.pin_b;
   assign wave_pin_b_oe_n = state_ff.oe_b_n;

endmodule : timer8_waveform_mode_control

// >>> dv/timer8_chk.sv
`timescale 1ns/100ps
`include "timer8_regs.svh"

module timer8_chk
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic timer_tick_enable,
   input wire logic port_out_a,
   input wire logic port_dir_a,
   input wire logic port_out_b,
   input wire logic port_dir_b,
   input wire logic wave_pin_a,
   input wire logic wave_pin_a_oe_n,
   input wire logic wave_pin_b,
   input wire logic wave_pin_b_oe_n
);
   // ****************************************************************
   // Shadow of the control fields, rebuilt from bus writes
   // ****************************************************************
   logic pend_ff;
   logic [7:0] wa_ff;
   logic [7:0] ca_ff;
   logic cb_ff;
   wire logic take = hsel && hready && htrans[1];
   wire logic [1:0] fa = ca_ff[7:6];
   wire logic [1:0] fb = ca_ff[5:4];

   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         pend_ff <= 1'h0;
         wa_ff <= 8'h00;
         ca_ff <= 8'h00;
         cb_ff <= 1'h0;
      end
      else
      begin
         pend_ff <= take && hwrite && hsize == 3'h2;
         wa_ff <= haddr[7:0];
         if (pend_ff && wa_ff == `OFS_CTRL_A)
            ca_ff <= hwdata[7:0] & 8'hF3;
         if (pend_ff && wa_ff == `OFS_CTRL_B)
            cb_ff <= hwdata[3];
      end
   end

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   sequence s_rd_a;
      take && !hwrite && haddr[7:0] == `OFS_CTRL_A;
   endsequence
   sequence s_rd_b;
      take && !hwrite && haddr[7:0] == `OFS_CTRL_B;
   endsequence

   a_oe_a_dir: assert property ($past(resetn) |-> wave_pin_a_oe_n == !$past(port_dir_a))
      else $error("pin A driver enable does not follow direction");
   a_oe_b_dir: assert property ($past(resetn) |-> wave_pin_b_oe_n == !$past(port_dir_b))
      else $error("pin B driver enable does not follow direction");
   a_pin_a_port: assert property ($past(resetn) && $past(fa) == 2'h0 |-> wave_pin_a == $past(port_out_a))
      else $error("pin A not on port value while disconnected");
   a_pin_b_port: assert property ($past(resetn) && $past(fb) == 2'h0 |-> wave_pin_b == $past(port_out_b))
      else $error("pin B not on port value while disconnected");
   a_resv_zero: assert property (s_rd_a |=> hrdata[3:2] == 2'h0 && hrdata[31:8] == 24'h00_0000)
      else $error("control A unused bits read nonzero");
   a_ctrl_a_back: assert property (s_rd_a ##1 1'h1 |-> hrdata[7:0] == $past(ca_ff))
      else $error("control A read differs from written fields");
   a_mode_back: assert property (s_rd_b |=> hrdata == {28'h000_0000, $past(cb_ff), 3'h0})
      else $error("mode high bit read differs");
   a_tick_gate_a: assert property ($past(fa) != 2'h0 && $past(fa, 2) != 2'h0
      && !$past(timer_tick_enable, 2) |-> $stable(wave_pin_a))
      else $error("wave A moved without a timer tick");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not OKAY");
endmodule : timer8_chk

// >>> dv/timer8_waveform_mode_control_bench.sv
`timescale 1ns/100ps
`include "timer8_regs.svh"

module timer8_waveform_mode_control_bench;
   import timer8_pkg::*;
   logic clk_sys = 1'h0;
   logic resetn = 1'h0;
   logic hsel = 1'h0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic timer_tick_enable = 1'h0;
   logic port_out_a = 1'h1;
   logic port_dir_a = 1'h1;
   logic port_out_b = 1'h0;
   logic port_dir_b = 1'h0;
   logic wave_pin_a, wave_pin_a_oe_n, wave_pin_b, wave_pin_b_oe_n;
   int errors = 0;
   int total_checks = 0;

   timer8_waveform_mode_control u_dut
   (
      .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .timer_tick_enable(timer_tick_enable),
      .port_out_a(port_out_a), .port_dir_a(port_dir_a), .port_out_b(port_out_b),
      .port_dir_b(port_dir_b), .wave_pin_a(wave_pin_a), .wave_pin_a_oe_n(wave_pin_a_oe_n),
      .wave_pin_b(wave_pin_b), .wave_pin_b_oe_n(wave_pin_b_oe_n)
   );

   always #5 clk_sys = ~clk_sys;

   // ****************************************************************
   // Compare, bus and tick tasks
   // ****************************************************************
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic cmp_pins(input logic [1:0] exp);
      total_checks++;
      if ({wave_pin_a, wave_pin_b} !== exp)
      begin
         errors++;
         $display("[FAIL] %0t pins %b expected %b", $time, {wave_pin_a, wave_pin_b}, exp);
      end
   endtask : cmp_pins

   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge clk_sys);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'h1, d, q);
   endtask : wr

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(a, 1'h0, 32'h0000_0000, q);
      cmp(q, exp);
   endtask : rc

   task automatic ctl(input logic [2:0] m, input logic [1:0] ca, input logic [1:0] cb);
      wr(`OFS_CTRL_A, {24'h00_0000, ca, cb, 2'h0, m[1:0]});
      wr(`OFS_CTRL_B, {28'h000_0000, m[2], 3'h0});
   endtask : ctl

   // Wave lands at the last tick edge, pins one edge later
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge clk_sys);
         timer_tick_enable <= 1'h1;
      end
      @(posedge clk_sys);
      timer_tick_enable <= 1'h0;
      repeat (2) @(posedge clk_sys);
   endtask : tick

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs();
      rc(`OFS_CTRL_A, 32'h0000_0000);
      rc(`OFS_CTRL_B, 32'h0000_0000);
      wr(`OFS_CTRL_A, 32'h0000_00FF);
      rc(`OFS_CTRL_A, 32'h0000_00F3);
      wr(`OFS_CTRL_B, 32'h0000_00FF);
      rc(`OFS_CTRL_B, 32'h0000_0008);
      rc(8'h40, 32'h0000_0000);
      ctl(3'h0, 2'h0, 2'h0);
      port_dir_b <= 1'h1;
      $display("t_regs done");
   endtask : t_regs

   task automatic t_nonpwm();
      logic [1:0] code [3] = '{2'h3, 2'h2, 2'h1};
      logic [1:0] pins [3] = '{2'h3, 2'h0, 2'h3};
      wr(`OFS_MATCH_A, 32'h0000_00FE);
      wr(`OFS_MATCH_B, 32'h0000_00FE);
      for (int i = 0; i < 3; i++)
      begin
         ctl(3'h0, code[i], code[i]);
         wr(`OFS_COUNT, 32'h0000_00FC);
         tick(4);
         cmp_pins(pins[i]);
      end
      rc(`OFS_FLAGS, 32'h0000_0007);
      wr(`OFS_FLAGS, 32'h0000_0007);
      rc(`OFS_FLAGS, 32'h0000_0000);
      $display("t_nonpwm done");
   endtask : t_nonpwm

   task automatic t_top();
      logic [2:0] mode [2] = '{3'h2, 3'h7};
      logic [31:0] flags [2] = '{32'h0000_0002, 32'h0000_0003};
      ctl(3'h0, 2'h0, 2'h0);
      wr(`OFS_MATCH_A, 32'h0000_000F);
      for (int i = 0; i < 2; i++)
      begin
         ctl(mode[i], 2'h0, 2'h0);
         wr(`OFS_COUNT, 32'h0000_0000);
         wr(`OFS_FLAGS, 32'h0000_0007);
         tick(16);
         rc(`OFS_COUNT, 32'h0000_0000);
         rc(`OFS_FLAGS, flags[i]);
      end
      $display("t_top done");
   endtask : t_top

   task automatic t_fast();
      ctl(3'h0, 2'h0, 2'h0);
      wr(`OFS_MATCH_A, 32'h0000_0030);
      wr(`OFS_MATCH_B, 32'h0000_0030);
      ctl(3'h3, 2'h2, 2'h3);
      wr(`OFS_COUNT, 32'h0000_00F0);
      tick(16);
      cmp_pins(2'h2);
      rc(`OFS_COUNT, 32'h0000_0000);
      wr(`OFS_FLAGS, 32'h0000_0007);
      wr(`OFS_MATCH_A, 32'h0000_0008);
      wr(`OFS_MATCH_B, 32'h0000_0008);
      rc(`OFS_MATCH_A, 32'h0000_0008);
      tick(10);
      cmp_pins(2'h2);
      tick(40);
      cmp_pins(2'h1);
      tick(206);
      cmp_pins(2'h2);
      rc(`OFS_FLAGS, 32'h0000_0007);
      tick(9);
      cmp_pins(2'h1);
      $display("t_fast done");
   endtask : t_fast

   task automatic t_phase();
      ctl(3'h0, 2'h0, 2'h0);
      wr(`OFS_MATCH_A, 32'h0000_00FE);
      wr(`OFS_MATCH_B, 32'h0000_00FE);
      ctl(3'h1, 2'h3, 2'h2);
      wr(`OFS_COUNT, 32'h0000_00FB);
      wr(`OFS_FLAGS, 32'h0000_0007);
      tick(4);
      rc(`OFS_COUNT, 32'h0000_00FF);
      cmp_pins(2'h2);
      tick(2);
      rc(`OFS_COUNT, 32'h0000_00FD);
      cmp_pins(2'h1);
      rc(`OFS_FLAGS, 32'h0000_0006);
      $display("t_phase done");
   endtask : t_phase

   task automatic t_special();
      ctl(3'h0, 2'h0, 2'h0);
      wr(`OFS_MATCH_A, 32'h0000_00FF);
      wr(`OFS_MATCH_B, 32'h0000_00FF);
      ctl(3'h3, 2'h2, 2'h3);
      wr(`OFS_COUNT, 32'h0000_00FD);
      tick(4);
      cmp_pins(2'h2);
      ctl(3'h0, 2'h0, 2'h0);
      wr(`OFS_MATCH_A, 32'h0000_0003);
      ctl(3'h7, 2'h1, 2'h0);
      wr(`OFS_COUNT, 32'h0000_0000);
      tick(4);
      cmp_pins(2'h0);
      tick(4);
      cmp_pins(2'h2);
      $display("t_special done");
   endtask : t_special

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   initial
   begin
      repeat (8) @(posedge clk_sys);
      resetn <= 1'h1;
      t_regs();
      t_nonpwm();
      t_top();
      t_fast();
      t_phase();
      t_special();
      close_out();
   end

   // Whole run needs well under two thousand cycles
   initial
   begin
      #100_000;
      errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      close_out();
   end
endmodule : timer8_waveform_mode_control_bench

bind timer8_waveform_mode_control timer8_chk u_chk
(
   .clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp),
   .timer_tick_enable(timer_tick_enable), .port_out_a(port_out_a), .port_dir_a(port_dir_a),
   .port_out_b(port_out_b), .port_dir_b(port_dir_b), .wave_pin_a(wave_pin_a),
   .wave_pin_a_oe_n(wave_pin_a_oe_n), .wave_pin_b(wave_pin_b), .wave_pin_b_oe_n(wave_pin_b_oe_n)
);
